//--- bench/dpsc_host_model.sv
/*
 * host model driving the serial command link of the pot command unit.
 * assumes mode 0 framing: sclk idle low, msb first, 16 clocks per frame,
 * and that callers enter xfer just after a rising edge of ref_clk_i.
 */
`timescale 1ns/10ps
module dpsc_host_model #(
    parameter int HALF = 8
) (
    input  wire logic ref_clk_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end

    // ------------------------------------------------------------------------
    // released data line toggles so a stale bit cannot pass
    // ------------------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (cs_n_o) begin
            sdi_o <= ~sdi_o;
        end
    end

    // ------------------------------------------------------------------------
    // one full frame, sdo taken just before each sclk rise
    // ------------------------------------------------------------------------
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n_o <= 1'b0;
        repeat (HALF) @(posedge ref_clk_i);
        for (int i = 15; i >= 0; i--) begin
            sdi_o <= tx[i];
            repeat (HALF - 1) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
            rx[i] = sdo_i;
            @(posedge ref_clk_i);
            sclk_o <= 1'b1;
            repeat (HALF) @(posedge ref_clk_i);
            sclk_o <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk_i);
        cs_n_o <= 1'b1;
        repeat (HALF) @(posedge ref_clk_i);
    endtask
endmodule

//--- bench/tb.sv
/*
 * self-checking bench for the pot command unit: directed and random frames.
 * assumes dpsc_map.svh on the include path and the host model beside it.
 */
`timescale 1ns/10ps
`include "dpsc_map.svh"
module tb;
    logic        ref_clk_i = 1'b0;
    logic        sys_rst_i, wp_n, pre_n, sclk, cs_n, sdi, sdo, idle;
    logic [7:0]  w1, w2, m_w1, m_w2;
    logic [7:0]  m_nv [16];
    logic [15:0] m_prev, rx;
    logic        m_idle, m_rd;
    logic [3:0]  m_ra, op, ad;
    logic [31:0] seed;
    int          fails = 0;
    int          comparisons = 0;
    logic [3:0]  ops [8] = '{`DPSC_OP_NOP, `DPSC_OP_SAVE, `DPSC_OP_STORE, `DPSC_OP_READ,
                             `DPSC_OP_LOAD, `DPSC_OP_SHL, `DPSC_OP_INC, `DPSC_OP_NOP};
    logic [15:0] dir [17] = '{16'hB140, 16'hB080, 16'hB040, 16'hE000, 16'hE000, 16'h2000,
                              16'hC100, 16'hC100, 16'h3280, 16'h3340, 16'h3011, 16'h9400,
                              16'h0000, 16'h9300, 16'h9200, 16'hB0FF, 16'hE000};

    always #4 ref_clk_i = ~ref_clk_i;

    dpsc_core uut (
        .ref_clk_i           (ref_clk_i),
        .sys_rst_i           (sys_rst_i),
        .sclk_i              (sclk),
        .cs_n_i              (cs_n),
        .sdi_i               (sdi),
        .write_protect_n_i   (wp_n),
        .preset_strobe_n_i   (pre_n),
        .sdo_o               (sdo),
        .wiper_setting_ch1_o (w1),
        .wiper_setting_ch2_o (w2),
        .idle_o              (idle)
    );

    dpsc_host_model #(.HALF(8)) host (
        .ref_clk_i (ref_clk_i),
        .sclk_o    (sclk),
        .cs_n_o    (cs_n),
        .sdi_o     (sdi),
        .sdo_i     (sdo)
    );

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("counts: fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check_outs;
        check("wiper1", {8'h00, w1}, {8'h00, m_w1});
        check("wiper2", {8'h00, w2}, {8'h00, m_w2});
        check("idle", {15'h0000, idle}, {15'h0000, m_idle});
    endtask

    task automatic set_wp(input logic v);
        wp_n <= v;
        repeat (8) @(posedge ref_clk_i);
    endtask

    task automatic preset;
        pre_n <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        pre_n <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        if (wp_n) begin
            m_w1 = m_nv[`DPSC_AD_CH1];
            m_w2 = m_nv[`DPSC_AD_CH2];
        end
        check_outs();
    endtask

    // ------------------------------------------------------------------------
    // one frame with the reference model applied afterwards
    // ------------------------------------------------------------------------
    task automatic frame(input logic [3:0] fo, input logic [3:0] fa, input logic [7:0] fd);
        logic [15:0] f;
        logic [7:0]  v;
        f = {fo, fa, fd};
        host.xfer(f, rx);
        repeat (8) @(posedge ref_clk_i);
        if (m_rd) check("readback", rx, {8'h00, m_nv[m_ra]});
        else check("echo", rx, m_prev);
        m_rd   = (fo == `DPSC_OP_READ);
        m_ra   = fa;
        m_prev = f;
        m_idle = (fo == `DPSC_OP_NOP);
        v = fa[0] ? m_w2 : m_w1;
        case (fo)
            `DPSC_OP_LOAD:  v = fd;
            `DPSC_OP_INC:   v = (v == 8'hFF) ? v : v + 8'h01;
            `DPSC_OP_SHL:   v = v[7] ? 8'hFF : {v[6:0], 1'b0};
            `DPSC_OP_SAVE:  if (wp_n) m_nv[fa] = v;
            `DPSC_OP_STORE: if (wp_n && fa > `DPSC_AD_CH2) m_nv[fa] = fd;
            default: ;
        endcase
        if (wp_n && (fo inside {`DPSC_OP_LOAD, `DPSC_OP_INC, `DPSC_OP_SHL})) begin
            if (fa[0]) m_w2 = v;
            else m_w1 = v;
        end
        check_outs();
    endtask

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst_i = 1'b1;
        wp_n      = 1'b1;
        pre_n     = 1'b1;
        seed      = 32'h0000_09e0;
        m_w1      = `DPSC_NV_RST;
        m_w2      = `DPSC_NV_RST;
        m_idle    = 1'b1;
        m_rd      = 1'b0;
        m_ra      = 4'h0;
        m_prev    = 16'h0000;
        foreach (m_nv[i]) m_nv[i] = `DPSC_NV_RST;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        check("sdo", {15'h0000, sdo}, 16'h0000);
        check_outs();
        foreach (dir[i]) frame(dir[i][15:12], dir[i][11:8], dir[i][7:0]);
        frame(`DPSC_OP_NOP, 4'h0, 8'h00);
        set_wp(1'b0);
        frame(`DPSC_OP_LOAD, `DPSC_AD_CH1, 8'h12);
        frame(`DPSC_OP_STORE, `DPSC_AD_SPARE3, 8'h33);
        preset();
        set_wp(1'b1);
        preset();
        for (int k = 0; k < 180; k++) begin
            seed = xs(seed);
            op = ops[seed[2:0]];
            ad = seed[11:8];
            if (op inside {`DPSC_OP_SAVE, `DPSC_OP_LOAD, `DPSC_OP_INC}) ad = {3'b000, seed[8]};
            if (op == `DPSC_OP_SHL) ad = `DPSC_AD_CH2;
            if (seed[30:28] == 3'h0) set_wp(~wp_n);
            if (seed[27:25] == 3'h0) preset();
            frame(op, ad, seed[23:16]);
        end
        give_verdict();
    end

    // ------------------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge ref_clk_i);
        fails++;
        give_verdict();
    end
endmodule

//--- hw/dpsc_core.sv
/*
 * serial command decoder of a dual channel nonvolatile digital potentiometer.
 * assumes an spi mode 0 host: sclk idle low, sdi sampled on rising edge,
 * sdo changes on falling edge, msb first, cs_n low frames 16 clocks.
 */
`timescale 1ns/10ps
`include "dpsc_map.svh"
// Contract
// - shift-left on channel 2 doubles wiper
// - store writes low byte to spare slot
// - read-prepare latches spare slot for next frame
// - next frame returns byte in last eight bits
// - nop returns device to idle state
// - write-protect low blocks wiper setting changes
// - preset strobe reloads wipers from nonvolatile copies
// - load on channel 1 copies byte
// - increment on channel 1 adds one
// - save on channel 1 copies wiper to nonvolatile
module dpsc_core (
    input  wire logic       ref_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       sdi_i,
    input  wire logic       write_protect_n_i,
    input  wire logic       preset_strobe_n_i,
    output logic            sdo_o,
    output logic [7:0]      wiper_setting_ch1_o,
    output logic [7:0]      wiper_setting_ch2_o,
    output logic            idle_o
);
    logic                   sclk_s;
    logic                   cs_n_s;
    logic                   sdi_s;
    logic                   wp_n_s;
    logic                   pst_n_s;
    logic                   sclk_q;
    logic                   cs_n_q;
    logic                   pst_n_q;
    logic [3:0]             cnt_q;
    logic [15:0]            rx_q;
    logic [15:0]            tx_q;
    logic [15:0]            echo_q;
    logic [7:0]             nv_q [`DPSC_NV_SLOTS];
    logic [7:0]             rd_byte_q;
    dpsc_pkg::dpsc_rd_state_t rd_q;
    dpsc_pkg::dpsc_frame_t  fr;
    logic                   rise;
    logic                   fall;
    logic                   frame_end;
    logic                   frame_start;
    logic                   preset;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    dpsc_sync #(.RST_VAL(1'b0)) u_sclk (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .pin_i(sclk_i), .level_o(sclk_s));
    dpsc_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .pin_i(cs_n_i), .level_o(cs_n_s));
    dpsc_sync #(.RST_VAL(1'b0)) u_sdi (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .pin_i(sdi_i), .level_o(sdi_s));
    dpsc_sync #(.RST_VAL(1'b1)) u_wp (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .pin_i(write_protect_n_i), .level_o(wp_n_s));
    dpsc_sync #(.RST_VAL(1'b1)) u_pst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .pin_i(preset_strobe_n_i), .level_o(pst_n_s));

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_q  <= 1'b0;
            cs_n_q  <= 1'b1;
            pst_n_q <= 1'b1;
        end else begin
            sclk_q  <= sclk_s;
            cs_n_q  <= cs_n_s;
            pst_n_q <= pst_n_s;
        end
    end

    assign rise        = sclk_s & ~sclk_q & ~cs_n_s;
    assign fall        = ~sclk_s & sclk_q & ~cs_n_s;
    assign frame_start = cs_n_q & ~cs_n_s;
    assign frame_end   = rise && (cnt_q == `DPSC_CNT_LAST);
    assign fr          = {rx_q[14:0], sdi_s};
    assign preset      = pst_n_q & ~pst_n_s;

    // ------------------------------------------------------------------------
    // receive shifter and bit counter
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            rx_q  <= '0;
        end else if (cs_n_s) begin
            cnt_q <= '0;
        end else if (rise) begin
            cnt_q <= cnt_q + 4'h1;
            rx_q  <= fr;
        end
    end

    // ------------------------------------------------------------------------
    // read-prepare state and daisy chain copy
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_q      <= dpsc_pkg::DPSC_IDLE;
            rd_byte_q <= '0;
            echo_q    <= '0;
            idle_o    <= 1'b1;
        end else if (frame_end) begin
            echo_q <= fr;
            if (fr.op == `DPSC_OP_READ) begin
                rd_q      <= dpsc_pkg::DPSC_ARMED;
                rd_byte_q <= nv_q[fr.addr];
                idle_o    <= 1'b0;
            end else begin
                rd_q <= dpsc_pkg::DPSC_IDLE;
                if (fr.op == `DPSC_OP_NOP) begin
                    idle_o <= 1'b1;
                end
            end
        end else if (rise && cnt_q == '0) begin
            idle_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // transmit shifter, loaded at frame start
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_q  <= '0;
            sdo_o <= 1'b0;
        end else if (frame_start) begin
            if (rd_q == dpsc_pkg::DPSC_ARMED) begin
                tx_q  <= {8'h00, rd_byte_q};
                sdo_o <= 1'b0;
            end else begin
                tx_q  <= echo_q;
                sdo_o <= echo_q[15];
            end
        end else if (fall && cnt_q != '0) begin
            tx_q  <= {tx_q[14:0], 1'b0};
            sdo_o <= tx_q[14];
        end
    end

    // ------------------------------------------------------------------------
    // wiper settings
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wiper_setting_ch1_o <= `DPSC_NV_RST;
            wiper_setting_ch2_o <= `DPSC_NV_RST;
        end else if (!wp_n_s) begin
            wiper_setting_ch1_o <= wiper_setting_ch1_o;
        end else if (preset) begin
            wiper_setting_ch1_o <= nv_q[`DPSC_AD_CH1];
            wiper_setting_ch2_o <= nv_q[`DPSC_AD_CH2];
        end else if (frame_end) begin
            unique case (fr.op)
                `DPSC_OP_LOAD: begin
                    if (fr.addr == `DPSC_AD_CH1) wiper_setting_ch1_o <= fr.data;
                    if (fr.addr == `DPSC_AD_CH2) wiper_setting_ch2_o <= fr.data;
                end
                `DPSC_OP_INC: begin
                    if (fr.addr == `DPSC_AD_CH1 && wiper_setting_ch1_o != `DPSC_BYTE_MAX)
                        wiper_setting_ch1_o <= wiper_setting_ch1_o + `DPSC_BYTE_ONE;
                    if (fr.addr == `DPSC_AD_CH2 && wiper_setting_ch2_o != `DPSC_BYTE_MAX)
                        wiper_setting_ch2_o <= wiper_setting_ch2_o + `DPSC_BYTE_ONE;
                end
                `DPSC_OP_SHL: begin
                    if (fr.addr == `DPSC_AD_CH2)
                        wiper_setting_ch2_o <= dbl(wiper_setting_ch2_o);
                    if (fr.addr == `DPSC_AD_CH1)
                        wiper_setting_ch1_o <= dbl(wiper_setting_ch1_o);
                end
                default: begin
                end
            endcase
        end
    end

    function automatic logic [7:0] dbl(input logic [7:0] v);
        dbl = v[`DPSC_DATA_HI] ? `DPSC_BYTE_MAX : {v[6:0], 1'b0};
    endfunction

    // ------------------------------------------------------------------------
    // nonvolatile copies and spare slots
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < `DPSC_NV_SLOTS; i++) nv_q[i] <= `DPSC_NV_RST;
        end else if (frame_end && wp_n_s) begin
            if (fr.op == `DPSC_OP_SAVE && fr.addr == `DPSC_AD_CH1)
                nv_q[`DPSC_AD_CH1] <= wiper_setting_ch1_o;
            if (fr.op == `DPSC_OP_SAVE && fr.addr == `DPSC_AD_CH2)
                nv_q[`DPSC_AD_CH2] <= wiper_setting_ch2_o;
            if (fr.op == `DPSC_OP_STORE && fr.addr >= `DPSC_AD_SPARE1)
                nv_q[fr.addr] <= fr.data;
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    shl_ch2_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_end && wp_n_s && !preset && fr.op == `DPSC_OP_SHL && fr.addr == `DPSC_AD_CH2
        |=> wiper_setting_ch2_o == dbl($past(wiper_setting_ch2_o)))
        else $error("shift left did not double channel 2");
    store_spare_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_end && wp_n_s && fr.op == `DPSC_OP_STORE && fr.addr == `DPSC_AD_SPARE1
        |=> nv_q[`DPSC_AD_SPARE1] == $past(fr.data))
        else $error("spare store lost");
    read_arm_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_end && fr.op == `DPSC_OP_READ |=> rd_q == dpsc_pkg::DPSC_ARMED)
        else $error("read not armed");
    read_load_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_start && rd_q == dpsc_pkg::DPSC_ARMED |=> tx_q[7:0] == $past(rd_byte_q))
        else $error("readback byte not loaded");
    nop_idle_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_end && fr.op == `DPSC_OP_NOP |=> idle_o)
        else $error("nop did not idle");
    wp_hold_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        !wp_n_s |=> $stable(wiper_setting_ch1_o) && $stable(wiper_setting_ch2_o))
        else $error("wiper changed under protect");
    preset_load_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        preset && wp_n_s |=> wiper_setting_ch1_o == $past(nv_q[`DPSC_AD_CH1]))
        else $error("preset did not reload");
    load_ch1_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_end && wp_n_s && !preset && fr.op == `DPSC_OP_LOAD && fr.addr == `DPSC_AD_CH1
        |=> wiper_setting_ch1_o == $past(fr.data))
        else $error("load channel 1 failed");
    echo_load_a: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
        frame_start && rd_q == dpsc_pkg::DPSC_IDLE |=> tx_q == $past(echo_q))
        else $error("echo frame not loaded");
    cov_read_c:  cover property (@(posedge ref_clk_i) frame_end && fr.op == `DPSC_OP_READ);
    cov_shl_c:   cover property (@(posedge ref_clk_i) frame_end && fr.op == `DPSC_OP_SHL);
    cov_pre_c:   cover property (@(posedge ref_clk_i) preset);
endmodule

//--- hw/dpsc_map.svh
/*
 * constants for the dual pot serial command unit: opcodes, addresses, widths.
 * assumes 16-bit frames, msb first, opcode in bits 15:12, address in 11:8.
 */
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH

// ----------------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------------
`define DPSC_FRAME_W      5'h10
`define DPSC_CNT_LAST     4'hF
`define DPSC_OP_HI        15
`define DPSC_OP_LO        12
`define DPSC_AD_HI        11
`define DPSC_AD_LO        8
`define DPSC_DATA_HI      7

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define DPSC_OP_NOP       4'h0
`define DPSC_OP_SAVE      4'h2
`define DPSC_OP_STORE     4'h3
`define DPSC_OP_READ      4'h9
`define DPSC_OP_LOAD      4'hB
`define DPSC_OP_SHL       4'hC
`define DPSC_OP_INC       4'hE

// ----------------------------------------------------------------------------
// addresses and reset values
// ----------------------------------------------------------------------------
`define DPSC_AD_CH1       4'h0
`define DPSC_AD_CH2       4'h1
`define DPSC_AD_SPARE1    4'h2
`define DPSC_AD_SPARE2    4'h3
`define DPSC_AD_SPARE3    4'h4
`define DPSC_NV_SLOTS     16
`define DPSC_NV_RST       8'h80
`define DPSC_BYTE_MAX     8'hFF
`define DPSC_BYTE_ONE     8'h01

`endif

//--- hw/dpsc_pkg.sv
/*
 * types for the dual pot serial command unit.
 * assumes dpsc_map.svh is included by the design files.
 */
package dpsc_pkg;

    // ------------------------------------------------------------------------
    // decoded command frame
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [7:0] data;
    } dpsc_frame_t;

    typedef enum logic [1:0] {
        DPSC_IDLE  = 2'b00,
        DPSC_ARMED = 2'b01
    } dpsc_rd_state_t;

endpackage

//--- hw/dpsc_sync.sv
/*
 * three-flop synchroniser with agreement filter for a pin input.
 * assumes the pin is asynchronous to ref_clk_i.
 */
`timescale 1ns/10ps
module dpsc_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic pin_i,
    output logic      level_o
);
    logic [2:0] sh_q;

    // ------------------------------------------------------------------------
    // sample chain, output moves when stages two and three agree
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sh_q <= {3{RST_VAL}};
        end else begin
            sh_q <= {sh_q[1:0], pin_i};
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_o <= RST_VAL;
        end else if (sh_q[1] == sh_q[2]) begin
            level_o <= sh_q[2];
        end
    end
endmodule
